/* File: core/ncpb_pkg.sv */
// Package with offsets, widths and reset values of the NCO preset bank
package ncpb_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PHASE_W = 16;
    localparam logic [11:0] OFS_A3_FREQ = 12'h238;
    localparam logic [11:0] OFS_A3_PHASE = 12'h23C;
    localparam logic [11:0] OFS_B0_FREQ = 12'h240;
    localparam logic [11:0] OFS_B0_PHASE = 12'h244;
    localparam logic [11:0] OFS_B1_FREQ = 12'h248;
    localparam logic [11:0] OFS_B1_PHASE = 12'h24C;
    localparam logic [11:0] OFS_B2_FREQ = 12'h250;
    localparam logic [11:0] OFS_B2_PHASE = 12'h254;
    localparam logic [11:0] OFS_B3_FREQ = 12'h258;
    localparam logic [11:0] OFS_B3_PHASE = 12'h25C;
    localparam logic [31:0] FREQ_RST = 32'hC0000000;
    localparam logic [15:0] PHASE_RST = 16'h0000;
endpackage : ncpb_pkg

/* File: core/ncpb_wr_if.sv */
// Interface carrying a register write strobe and data to a preset word
`timescale 1ns/1ps
`default_nettype none
interface ncpb_wr_if;
    logic we;
    logic [31:0] wdata;
    modport src (output we, output wdata);
    modport dst (input we, input wdata);
endinterface : ncpb_wr_if
`default_nettype wire

/* File: core/ncpb_word.sv */
// One read-write preset word with a reset value
`timescale 1ns/1ps
`default_nettype none
module ncpb_word #(
    parameter int W = 32,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    ncpb_wr_if.dst wr,
    output logic [W-1:0] o_value
);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_value <= RST;
        end else if (wr.we) begin
            o_value <= wr.wdata[W-1:0];
        end
    end
endmodule : ncpb_word
`default_nettype wire

/* File: core/ncpb_bank.sv */
// NCO preset register bank: channel A preset 3 and channel B presets 0 to 3
`timescale 1ns/1ps
`default_nettype none
module ncpb_bank (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    output logic o_rd_valid,
    input wire logic i_interleaved,
    input wire logic [1:0] i_preset_sel,
    output logic [31:0] o_nco_a_freq,
    output logic [31:0] o_nco_a_phase,
    output logic [31:0] o_nco_b_freq,
    output logic [31:0] o_nco_b_phase
);
    localparam int N = 10;
    // Read decode table, same order as the val array below
    localparam logic [11:0] OFS [N] = '{
        ncpb_pkg::OFS_A3_FREQ, ncpb_pkg::OFS_A3_PHASE,
        ncpb_pkg::OFS_B0_FREQ, ncpb_pkg::OFS_B0_PHASE,
        ncpb_pkg::OFS_B1_FREQ, ncpb_pkg::OFS_B1_PHASE,
        ncpb_pkg::OFS_B2_FREQ, ncpb_pkg::OFS_B2_PHASE,
        ncpb_pkg::OFS_B3_FREQ, ncpb_pkg::OFS_B3_PHASE};
    logic [31:0] val [N];
    logic [31:0] rdata_q;
    logic rd_valid_q;
    logic [31:0] rdata_d;
    logic [15:0] ph_a3;
    logic [15:0] ph_b0;
    logic [15:0] ph_b1;
    logic [15:0] ph_b2;
    logic [15:0] ph_b3;
    ncpb_wr_if wif_a3_freq ();
    ncpb_wr_if wif_a3_phase ();
    ncpb_wr_if wif_b0_freq ();
    ncpb_wr_if wif_b0_phase ();
    ncpb_wr_if wif_b1_freq ();
    ncpb_wr_if wif_b1_phase ();
    ncpb_wr_if wif_b2_freq ();
    ncpb_wr_if wif_b2_phase ();
    ncpb_wr_if wif_b3_freq ();
    ncpb_wr_if wif_b3_phase ();

    assign wif_a3_freq.we = i_wr_en && (i_addr == ncpb_pkg::OFS_A3_FREQ);
    assign wif_a3_freq.wdata = i_wdata;
    ncpb_word #(
        .W(32),
        .RST(ncpb_pkg::FREQ_RST)
    ) u_a3_freq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_a3_freq),
        .o_value(val[0])
    );

    assign wif_a3_phase.we = i_wr_en && (i_addr == ncpb_pkg::OFS_A3_PHASE);
    assign wif_a3_phase.wdata = i_wdata;
    ncpb_word #(
        .W(16),
        .RST(ncpb_pkg::PHASE_RST)
    ) u_a3_phase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_a3_phase),
        .o_value(ph_a3)
    );
    assign val[1] = {16'h0000, ph_a3};

    assign wif_b0_freq.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B0_FREQ);
    assign wif_b0_freq.wdata = i_wdata;
    ncpb_word #(
        .W(32),
        .RST(ncpb_pkg::FREQ_RST)
    ) u_b0_freq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b0_freq),
        .o_value(val[2])
    );

    assign wif_b0_phase.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B0_PHASE);
    assign wif_b0_phase.wdata = i_wdata;
    ncpb_word #(
        .W(16),
        .RST(ncpb_pkg::PHASE_RST)
    ) u_b0_phase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b0_phase),
        .o_value(ph_b0)
    );
    assign val[3] = {16'h0000, ph_b0};

    assign wif_b1_freq.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B1_FREQ);
    assign wif_b1_freq.wdata = i_wdata;
    ncpb_word #(
        .W(32),
        .RST(ncpb_pkg::FREQ_RST)
    ) u_b1_freq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b1_freq),
        .o_value(val[4])
    );

    assign wif_b1_phase.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B1_PHASE);
    assign wif_b1_phase.wdata = i_wdata;
    ncpb_word #(
        .W(16),
        .RST(ncpb_pkg::PHASE_RST)
    ) u_b1_phase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b1_phase),
        .o_value(ph_b1)
    );
    assign val[5] = {16'h0000, ph_b1};

    assign wif_b2_freq.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B2_FREQ);
    assign wif_b2_freq.wdata = i_wdata;
    ncpb_word #(
        .W(32),
        .RST(ncpb_pkg::FREQ_RST)
    ) u_b2_freq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b2_freq),
        .o_value(val[6])
    );

    assign wif_b2_phase.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B2_PHASE);
    assign wif_b2_phase.wdata = i_wdata;
    ncpb_word #(
        .W(16),
        .RST(ncpb_pkg::PHASE_RST)
    ) u_b2_phase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b2_phase),
        .o_value(ph_b2)
    );
    assign val[7] = {16'h0000, ph_b2};

    assign wif_b3_freq.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B3_FREQ);
    assign wif_b3_freq.wdata = i_wdata;
    ncpb_word #(
        .W(32),
        .RST(ncpb_pkg::FREQ_RST)
    ) u_b3_freq (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b3_freq),
        .o_value(val[8])
    );

    // Channel B preset 3 phase sits in the word after its frequency
    assign wif_b3_phase.we = i_wr_en && (i_addr == ncpb_pkg::OFS_B3_PHASE);
    assign wif_b3_phase.wdata = i_wdata;
    ncpb_word #(
        .W(16),
        .RST(ncpb_pkg::PHASE_RST)
    ) u_b3_phase (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(wif_b3_phase),
        .o_value(ph_b3)
    );
    assign val[9] = {16'h0000, ph_b3};

    always_comb begin
        rdata_d = 32'h00000000;
        for (int i = 0; i < N; i++) begin
            if (i_addr == OFS[i]) begin
                rdata_d = val[i];
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 32'h00000000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
            if (i_rd_en) begin
                rdata_q <= rdata_d;
            end
        end
    end
    assign o_rdata = rdata_q;
    assign o_rd_valid = rd_valid_q;
    // Channel A only preset 3 is held here; other presets lie outside
    assign o_nco_a_freq = val[0];
    assign o_nco_a_phase = {val[1][15:0], 16'h0000};
    logic [3:0] bi;
    assign bi = {1'b0, i_preset_sel, 1'b0} + 4'h2;
    // interleaved mode uses channel A preset for channel B
    assign o_nco_b_freq = i_interleaved ? val[0] : val[bi];
    assign o_nco_b_phase = i_interleaved ? {val[1][15:0], 16'h0000}
                                         : {val[bi + 4'h1][15:0], 16'h0000};
endmodule : ncpb_bank
`default_nettype wire

/* File: testbench/ncpb_bank_monitor.sv */
// Port checker for the NCO preset bank
`timescale 1ns/1ps
`default_nettype none
module ncpb_bank_monitor (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic i_interleaved,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] o_nco_a_freq,
    input wire logic [31:0] o_nco_a_phase,
    input wire logic [31:0] o_nco_b_freq,
    input wire logic [31:0] o_nco_b_phase
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire fw = i_wr_en && i_addr == 12'h238;
    wire pw = i_wr_en && i_addr == 12'h23C;
    a_freq_write: assert property (fw |=> o_nco_a_freq == $past(i_wdata)) else $error("fw");
    a_phase_write: assert property (pw |=> o_nco_a_phase[31:16] == 16'($past(i_wdata)))
        else $error("pw");
    a_freq_hold: assert property (!fw |=> $stable(o_nco_a_freq)) else $error("fh");
    a_phase_hold: assert property (!pw |=> $stable(o_nco_a_phase)) else $error("ph");
    a_a_ljust: assert property (o_nco_a_phase[15:0] == 16'h0000) else $error("al");
    a_b_ljust: assert property (o_nco_b_phase[15:0] == 16'h0000) else $error("bl");
    a_il_freq: assert property (i_interleaved |-> o_nco_b_freq == o_nco_a_freq) else $error("bf");
    a_il_phase: assert property (i_interleaved |-> o_nco_b_phase == o_nco_a_phase) else $error("bp");
endmodule : ncpb_bank_monitor
bind ncpb_bank ncpb_bank_monitor i_mon (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_en(i_wr_en),
    .i_interleaved(i_interleaved),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .o_nco_a_freq(o_nco_a_freq),
    .o_nco_a_phase(o_nco_a_phase),
    .o_nco_b_freq(o_nco_b_freq),
    .o_nco_b_phase(o_nco_b_phase)
);
`default_nettype wire

/* File: testbench/ncpb_bank_test.sv */
// Random bench for the NCO preset bank
`timescale 1ns/1ps
`default_nettype none
module ncpb_bank_test;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, o_rd_valid;
    logic i_interleaved = 1'b0;
    logic [1:0] i_preset_sel = 2'h0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h0, s = 32'h1A, m [10], o_rdata, o_nco_a_freq, o_nco_a_phase;
    logic [31:0] o_nco_b_freq, o_nco_b_phase;
    int n_fail = 0, checks = 0;
    ncpb_bank i_dut (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid),
        .i_interleaved(i_interleaved),
        .i_preset_sel(i_preset_sel),
        .o_nco_a_freq(o_nco_a_freq),
        .o_nco_a_phase(o_nco_a_phase),
        .o_nco_b_freq(o_nco_b_freq),
        .o_nco_b_phase(o_nco_b_phase)
    );
    initial forever #4 i_clk = ~i_clk;
    function logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : rnd
    task chk(input string n, input logic [31:0] v, input logic [31:0] e);
        checks++;
        if (v !== e) n_fail++;
        if (v !== e) $display("CHECK FAILED %s exp %h seen %h", n, e, v);
    endtask : chk
    task acc(input logic w, input int k, input logic [31:0] d);
        logic [31:0] r;
        int bi;
        @(posedge i_clk);
        r = rnd();
        // no channel B write while interleaved
        {i_wr_en, i_rd_en, i_interleaved, i_preset_sel} <=
            {w, !w, r[2] && !(w && k > 1 && k < 10), r[1:0]};
        i_addr <= k < 10 ? 12'(12'h238 + 4 * k) : 12'h300;
        i_wdata <= d;
        @(posedge i_clk);
        {i_wr_en, i_rd_en} <= 2'h0;
        #1;
        chk("valid", 32'(o_rd_valid), 32'(!w));
        if (!w) chk("rdata", o_rdata, k < 10 ? m[k] : 32'h0);
        if (w && k < 10) m[k] = k[0] ? 32'(d[15:0]) : d;
        bi = i_interleaved ? 0 : 2 + 2 * int'(i_preset_sel);
        chk("bfreq", o_nco_b_freq, m[bi]);
        chk("bphase", o_nco_b_phase, {m[bi + 1][15:0], 16'h0000});
        chk("afreq", o_nco_a_freq, m[0]);
        chk("aphase", o_nco_a_phase, {m[1][15:0], 16'h0000});
    endtask : acc
    task test_done();
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 10; k++) m[k] = k[0] ? 32'h0 : 32'hC0000000;
        // reset reads, all-ones writes, random traffic
        for (int j = 0; j < 300; j++) begin
            acc(j > 10 && (j < 22 || s[0]), j < 22 ? j % 11 : int'(rnd() % 11),
                j < 22 ? 32'hFFFFFFFF : rnd());
        end
        test_done();
    end
endmodule : ncpb_bank_test
`default_nettype wire
